//--- tfg_pkg.sv
// Constants, register map and state types of the test frame generator.
// Assumes a 10 MHz APB clock and a byte-wide transmit datapath.
package tfg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_IRQ_MASK  = 16'h0018;
  localparam logic [15:0] IDX_IRQ_STAT  = 16'h0019;
  localparam logic [15:0] IDX_GEN_EN    = 16'h9415;
  localparam logic [15:0] IDX_CTRL      = 16'h9416;
  localparam logic [15:0] IDX_CONT      = 16'h9417;
  localparam logic [15:0] IDX_IRQ_EN    = 16'h9418;
  localparam logic [15:0] IDX_PAY_LEN   = 16'h941a;
  localparam logic [15:0] IDX_GAP_LEN   = 16'h941b;
  localparam logic [15:0] IDX_CNT_HIGH  = 16'h941c;
  localparam logic [15:0] IDX_CNT_LOW   = 16'h941d;
  localparam logic [15:0] IDX_DONE      = 16'h941e;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CG_BIT        = 7;
  localparam int          RESTART_BIT   = 3;
  localparam logic [2:0]  RST_PATTERN   = 3'h1;
  localparam logic [15:0] RST_PAY_LEN   = 16'h006b;
  localparam logic [7:0]  RST_GAP_LEN   = 8'h0c;
  localparam logic [15:0] RST_CNT_HIGH  = 16'h0000;
  localparam logic [15:0] RST_CNT_LOW   = 16'h0100;

  // ----------------------------------------------------------------
  // Frame layout and payload patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] DA_LAST       = 16'h0005;
  localparam logic [15:0] SA_LAST       = 16'h000b;
  localparam logic [15:0] LEN_HI_IDX    = 16'h000c;
  localparam logic [15:0] HDR_LAST      = 16'h000d;
  localparam logic [15:0] FCS_LAST      = 16'h0003;
  localparam logic [7:0]  DA_BYTE       = 8'hff;
  localparam logic [7:0]  SA_BYTE       = 8'h02;
  localparam logic [7:0]  ALT_BYTE      = 8'h55;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY      = 32'hedb88320;
  localparam logic [15:0] LFSR_SEED     = 16'hace1;
  localparam logic [15:0] LFSR_TAPS     = 16'hb400;
  localparam logic [2:0]  PAT_STOP      = 3'h0;
  localparam logic [2:0]  PAT_RANDOM    = 3'h1;
  localparam logic [2:0]  PAT_ZEROS     = 3'h2;
  localparam logic [2:0]  PAT_ONES      = 3'h3;
  localparam logic [2:0]  PAT_ALT       = 3'h4;
  localparam logic [2:0]  PAT_DECR      = 3'h5;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_PAY, ST_FCS, ST_GAP} tfg_state_t;

  typedef struct packed {
    tfg_state_t  st;
    logic [15:0] cnt;
    logic [31:0] left;
    logic [31:0] crc;
    logic [15:0] lfsr;
    logic        gen_en;
    logic        en_prev;
    logic [2:0]  pattern;
    logic        cont;
    logic        irq_en;
    logic [15:0] pay_len;
    logic [7:0]  gap_len;
    logic [15:0] cnt_high;
    logic [15:0] cnt_low;
    logic        done;
    logic        cg_mask;
    logic        cg_stat;
    logic [31:0] prdata;
    logic        tx_en;
    logic [7:0]  tx_data;
  } tfg_regs_t;

endpackage

//--- tfg_top.sv
// Test frame generator with APB register slave and transmit source mux.
// Assumes MAC transmit inputs are synchronous to pclk; one byte per enabled clock.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tfg_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        mac_tx_en,
  input  wire logic [7:0]  mac_tx_data,
  output logic             phy_tx_en,
  output logic [7:0]       phy_tx_data
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ tfg_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ tfg_pkg::LFSR_TAPS) : (s >> 1);
  endfunction

  function automatic logic hit(input logic [15:0] idx, input logic [15:0] reg_idx);
    return idx == reg_idx;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tfg_pkg::tfg_regs_t q;
  tfg_pkg::tfg_regs_t d;

  logic [15:0] idx;
  logic        mapped;
  logic        wr;
  logic        rd;
  logic        rd_setup;
  logic        start;
  logic        gen_valid;
  logic [7:0]  gen_byte;
  logic        frame_end;
  logic        done_set;
  logic [31:0] rdval;
  logic [31:0] crc_out;

  assign idx = paddr[17:2];

  always_comb
  begin
    mapped = hit(idx, tfg_pkg::IDX_IRQ_MASK) | hit(idx, tfg_pkg::IDX_IRQ_STAT) |
             hit(idx, tfg_pkg::IDX_GEN_EN) | hit(idx, tfg_pkg::IDX_CTRL) |
             hit(idx, tfg_pkg::IDX_CONT) | hit(idx, tfg_pkg::IDX_IRQ_EN) |
             hit(idx, tfg_pkg::IDX_PAY_LEN) | hit(idx, tfg_pkg::IDX_GAP_LEN) |
             hit(idx, tfg_pkg::IDX_CNT_HIGH) | hit(idx, tfg_pkg::IDX_CNT_LOW) |
             hit(idx, tfg_pkg::IDX_DONE);
  end

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  assign pready   = ce;
  assign pslverr  = psel & penable & ~mapped;
  assign prdata   = q.prdata;
  assign wr       = ce & psel & penable & pwrite & mapped;
  assign rd       = ce & psel & penable & ~pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign crc_out  = ~q.crc;

  // Read mux, reserved bits zero
  always_comb
  begin
    rdval = 32'h00000000;
    unique case (1'b1)
      hit(idx, tfg_pkg::IDX_IRQ_MASK): rdval[tfg_pkg::CG_BIT] = q.cg_mask;
      hit(idx, tfg_pkg::IDX_IRQ_STAT): rdval[tfg_pkg::CG_BIT] = q.cg_stat;
      hit(idx, tfg_pkg::IDX_GEN_EN):   rdval[0] = q.gen_en;
      hit(idx, tfg_pkg::IDX_CTRL):     rdval[2:0] = q.pattern;
      hit(idx, tfg_pkg::IDX_CONT):     rdval[0] = q.cont;
      hit(idx, tfg_pkg::IDX_IRQ_EN):   rdval[0] = q.irq_en;
      hit(idx, tfg_pkg::IDX_PAY_LEN):  rdval[15:0] = q.pay_len;
      hit(idx, tfg_pkg::IDX_GAP_LEN):  rdval[7:0] = q.gap_len;
      hit(idx, tfg_pkg::IDX_CNT_HIGH): rdval[15:0] = q.cnt_high;
      hit(idx, tfg_pkg::IDX_CNT_LOW):  rdval[15:0] = q.cnt_low;
      hit(idx, tfg_pkg::IDX_DONE):     rdval[0] = q.done;
      default:                         rdval = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Byte source of the generator
  // ----------------------------------------------------------------
  always_comb
  begin
    gen_valid = 1'b1;
    gen_byte  = 8'h00;
    unique case (q.st)
      tfg_pkg::ST_HDR:
      begin
        if (q.cnt <= tfg_pkg::DA_LAST)
          gen_byte = tfg_pkg::DA_BYTE;
        else if (q.cnt <= tfg_pkg::SA_LAST)
          gen_byte = tfg_pkg::SA_BYTE;
        else if (q.cnt == tfg_pkg::LEN_HI_IDX)
          gen_byte = q.pay_len[15:8];
        else
          gen_byte = q.pay_len[7:0];
      end
      tfg_pkg::ST_PAY:
      begin
        unique case (q.pattern)
          tfg_pkg::PAT_RANDOM: gen_byte = q.lfsr[7:0];
          tfg_pkg::PAT_ONES:   gen_byte = 8'hff;
          tfg_pkg::PAT_ALT:    gen_byte = tfg_pkg::ALT_BYTE;
          tfg_pkg::PAT_DECR:   gen_byte = ~q.cnt[7:0];
          default:             gen_byte = 8'h00;
        endcase
      end
      tfg_pkg::ST_FCS:
        gen_byte = 8'((crc_out >> {q.cnt[1:0], 3'h0}));
      tfg_pkg::ST_IDLE:
        gen_valid = 1'b0;
      tfg_pkg::ST_GAP:
        gen_valid = 1'b0;
    endcase
  end

  assign frame_end = (q.st == tfg_pkg::ST_FCS) && (q.cnt == tfg_pkg::FCS_LAST);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    start    = 1'b0;
    done_set = 1'b0;

    // Read data capture and register writes
    if (rd_setup)
      d.prdata = rdval;
    if (wr)
    begin
      unique case (1'b1)
        hit(idx, tfg_pkg::IDX_IRQ_MASK): d.cg_mask = pwdata[tfg_pkg::CG_BIT];
        hit(idx, tfg_pkg::IDX_GEN_EN):   d.gen_en = pwdata[0];
        hit(idx, tfg_pkg::IDX_CTRL):
        begin
          d.pattern = pwdata[2:0];
          start     = pwdata[tfg_pkg::RESTART_BIT];
        end
        hit(idx, tfg_pkg::IDX_CONT):     d.cont = pwdata[0];
        hit(idx, tfg_pkg::IDX_IRQ_EN):   d.irq_en = pwdata[0];
        hit(idx, tfg_pkg::IDX_PAY_LEN):  d.pay_len = pwdata[15:0];
        hit(idx, tfg_pkg::IDX_GAP_LEN):  d.gap_len = pwdata[7:0];
        hit(idx, tfg_pkg::IDX_CNT_HIGH): d.cnt_high = pwdata[15:0];
        hit(idx, tfg_pkg::IDX_CNT_LOW):  d.cnt_low = pwdata[15:0];
        default:                         d.cg_mask = q.cg_mask;
      endcase
    end
    if (wr && hit(idx, tfg_pkg::IDX_IRQ_STAT) && pwdata[tfg_pkg::CG_BIT])
      d.cg_stat = 1'b0;
    // Only a read that returned the flag clears it, so a set is never lost
    if (rd && hit(idx, tfg_pkg::IDX_DONE) && q.prdata[0])
      d.done = 1'b0;

    // Enable edge or restart begins a run with a fresh count
    d.en_prev = d.gen_en;
    start     = d.gen_en & (start | ~q.en_prev);

    // Generator sequencing
    unique case (q.st)
      tfg_pkg::ST_HDR:
      begin
        d.crc = crc_step(q.crc, gen_byte);
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == tfg_pkg::HDR_LAST)
        begin
          d.cnt = 16'h0000;
          d.st  = (q.pay_len == 16'h0000) ? tfg_pkg::ST_FCS : tfg_pkg::ST_PAY;
        end
      end
      tfg_pkg::ST_PAY:
      begin
        d.crc  = crc_step(q.crc, gen_byte);
        d.lfsr = lfsr_step(q.lfsr);
        d.cnt  = q.cnt + 16'h0001;
        if (q.cnt == q.pay_len - 16'h0001)
        begin
          d.cnt = 16'h0000;
          d.st  = tfg_pkg::ST_FCS;
        end
      end
      tfg_pkg::ST_FCS:
      begin
        d.cnt = q.cnt + 16'h0001;
        if (frame_end)
        begin
          d.cnt  = 16'h0000;
          d.crc  = tfg_pkg::CRC_INIT;
          d.left = q.left - 32'h00000001;
          if (q.pattern == tfg_pkg::PAT_STOP)
            d.st = tfg_pkg::ST_IDLE;
          else if (!q.cont && q.left == 32'h00000001)
          begin
            d.st     = tfg_pkg::ST_IDLE;
            done_set = 1'b1;
          end
          else if (q.gap_len == 8'h00)
            d.st = tfg_pkg::ST_HDR;
          else
            d.st = tfg_pkg::ST_GAP;
        end
      end
      tfg_pkg::ST_GAP:
      begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt[7:0] == q.gap_len - 8'h01)
        begin
          d.cnt = 16'h0000;
          d.st  = tfg_pkg::ST_HDR;
        end
      end
      tfg_pkg::ST_IDLE:
        d.cnt = 16'h0000;
    endcase

    if (start)
    begin
      d.left = {d.cnt_high, d.cnt_low};
      d.cnt  = 16'h0000;
      d.crc  = tfg_pkg::CRC_INIT;
      if (!d.cont && d.left == 32'h00000000)
      begin
        d.st     = tfg_pkg::ST_IDLE;
        done_set = 1'b1;
      end
      else
        d.st = tfg_pkg::ST_HDR;
    end
    if (!d.gen_en)
      d.st = tfg_pkg::ST_IDLE;

    // Completion flags; a set wins over a clear in the same cycle
    if (done_set)
    begin
      d.done = 1'b1;
      if (q.irq_en)
        d.cg_stat = 1'b1;
    end

    // Transmit source select
    if (q.gen_en)
    begin
      d.tx_en   = gen_valid;
      d.tx_data = gen_valid ? gen_byte : 8'h00;
    end
    else
    begin
      d.tx_en   = mac_tx_en;
      d.tx_data = mac_tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      q.st       <= tfg_pkg::ST_IDLE;
      q.crc      <= tfg_pkg::CRC_INIT;
      q.lfsr     <= tfg_pkg::LFSR_SEED;
      q.pattern  <= tfg_pkg::RST_PATTERN;
      q.pay_len  <= tfg_pkg::RST_PAY_LEN;
      q.gap_len  <= tfg_pkg::RST_GAP_LEN;
      q.cnt_high <= tfg_pkg::RST_CNT_HIGH;
      q.cnt_low  <= tfg_pkg::RST_CNT_LOW;
    end
    else if (ce)
      q <= d;
  end

  assign irq         = q.cg_stat & q.cg_mask;
  assign phy_tx_en   = q.tx_en;
  assign phy_tx_data = q.tx_data;

endmodule

`default_nettype wire

//--- tfg_phy_model.sv
// PHY transmit side model: counts generated frames and records their shape.
// Assumes generator frames open with the broadcast byte and MAC traffic never does.
`timescale 1ns/1ps
`default_nettype none
module tfg_phy_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       phy_tx_en,
  input  wire logic [7:0] phy_tx_data,
  output logic [15:0]     frames,
  output logic [15:0]     flen,
  output logic [15:0]     fgap,
  output logic [15:0]     lenf,
  output logic [15:0]     pbytes
);
  logic [15:0] pos;
  logic [15:0] idle;
  logic        gen;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {frames, flen, fgap, lenf, pbytes} <= '0;
      pos  <= 16'h0;
      idle <= 16'h0;
      gen  <= 1'b0;
    end
    else if (phy_tx_en)
    begin
      pos  <= pos + 16'h1;
      idle <= 16'h0;
      if (pos == 16'h0)
        gen <= (phy_tx_data == tfg_pkg::DA_BYTE);
      if (pos == 16'h0 && phy_tx_data == tfg_pkg::DA_BYTE)
        fgap <= idle;
      if (pos == 16'hc)
        lenf[15:8] <= phy_tx_data;
      if (pos == 16'hd)
        lenf[7:0] <= phy_tx_data;
      if (pos == 16'he)
        pbytes[15:8] <= phy_tx_data;
      if (pos == 16'hf)
        pbytes[7:0] <= phy_tx_data;
    end
    else
    begin
      idle <= idle + 16'h1;
      pos  <= 16'h0;
      // Only generator frames are counted
      if (pos != 16'h0 && gen)
      begin
        frames <= frames + 16'h1;
        flen   <= pos;
      end
    end
  end
endmodule
`default_nettype wire

//--- tfg_top_monitor.sv
// Port assertions for the test frame generator.
// Assumes bench MAC data stays below 0x80.
`timescale 1ns/1ps
`default_nettype none
module tfg_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        mac_tx_en,
  input wire logic [7:0]  mac_tx_data,
  input wire logic        phy_tx_en,
  input wire logic [7:0]  phy_tx_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  frame_layout_a: assert property ($rose(phy_tx_en) && phy_tx_data == tfg_pkg::DA_BYTE
    |-> (phy_tx_en && phy_tx_data == tfg_pkg::DA_BYTE)[*6]
    ##1 (phy_tx_en && phy_tx_data == tfg_pkg::SA_BYTE)[*6] ##1 phy_tx_en[*6]) else $error("bad frame");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  gap_bits_a: assert property (psel && penable && !pwrite
    && paddr[17:2] == tfg_pkg::IDX_GAP_LEN |-> prdata[15:8] == 8'h0) else $error("gap reserved set");
  flag_bits_a: assert property (psel && penable && !pwrite && (paddr[17:2] == tfg_pkg::IDX_CONT
    || paddr[17:2] == tfg_pkg::IDX_IRQ_EN || paddr[17:2] == tfg_pkg::IDX_DONE)
    |-> prdata[15:1] == 15'h0) else $error("flag reserved set");
  irq_fall_write_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
  irq_rise_cause_a: assert property ($rose(irq)
    |-> $past(psel && penable && pwrite) || $past(phy_tx_en) || $past(phy_tx_en, 2))
    else $error("irq rose without cause");
  rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data changed outside setup");
  bad_read_zero_a: assert property (psel && penable && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
endmodule

bind tfg_top tfg_top_monitor mon_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .irq, .mac_tx_en, .mac_tx_data, .phy_tx_en, .phy_tx_data);
`default_nettype wire

//--- tfg_top_tb.sv
// Self-checking bench for the test frame generator over APB.
// Assumes the PHY model and the bound port monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module tfg_top_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
  logic        mac_tx_en, phy_tx_en, rerr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  mac_tx_data, phy_tx_data, gap, md;
  logic [15:0] frames, flen, fgap, lenf, pbytes, base, pay;
  logic        me;
  integer      seed = 93;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [15:0] ridx [9] = '{tfg_pkg::IDX_GEN_EN, tfg_pkg::IDX_CTRL, tfg_pkg::IDX_CONT,
    tfg_pkg::IDX_IRQ_EN, tfg_pkg::IDX_PAY_LEN, tfg_pkg::IDX_GAP_LEN, tfg_pkg::IDX_CNT_HIGH,
    tfg_pkg::IDX_CNT_LOW, tfg_pkg::IDX_DONE};
  logic [31:0] rval [9] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h6b, 32'hc, 32'h0, 32'h100, 32'h0};

  tfg_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .mac_tx_en, .mac_tx_data, .phy_tx_en, .phy_tx_data);
  tfg_phy_model phy_u (.pclk, .presetn, .phy_tx_en, .phy_tx_data, .frames, .flen, .fgap,
    .lenf, .pbytes);

  always #50 pclk = ~pclk;

  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v);
  endtask

  task automatic chk_rd(input string n, input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK(n, e, rdat)
  endtask

  task automatic wait_done();
    rdat = 32'h0;
    for (int n = 0; n < 300 && rdat[0] !== 1'b1; n++)
      apb(1'b0, tfg_pkg::IDX_DONE, 32'h0);
  endtask

  function automatic logic [15:0] exp_pay(input logic [2:0] p);
    case (p)
      3'h2:    return 16'h0000;
      3'h3:    return 16'hffff;
      3'h4:    return 16'h5555;
      default: return 16'hfffe;
    endcase
  endfunction

  initial
  begin
    {pclk, presetn, ce, psel, penable, pwrite, mac_tx_en} = '0;
    {paddr, pwdata, mac_tx_data} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ce      <= 1'b1; // Diagnostic clock runs before any use
    for (int i = 0; i < 9; i++)
      chk_rd("reset value", ridx[i], rval[i]);
    wr(tfg_pkg::IDX_GAP_LEN, 32'hffffffff);
    chk_rd("gap bits", tfg_pkg::IDX_GAP_LEN, 32'hff);
    wr(tfg_pkg::IDX_CTRL, 32'hffffffff);
    chk_rd("ctrl bits", tfg_pkg::IDX_CTRL, 32'h7);
    apb(1'b0, 16'h9419, 32'h0);
    `CHK("unmapped", 33'h100000000, {rerr, rdat})
    wr(tfg_pkg::IDX_IRQ_EN, 32'h1);
    wr(tfg_pkg::IDX_CNT_LOW, 32'h2);
    for (int p = 2; p < 6; p++)
    begin
      pay = 16'd2 + 16'($random(seed) & 15);
      gap = 8'd1 + 8'($random(seed) & 7);
      md  = 8'($random(seed)) & 8'h7f;
      wr(tfg_pkg::IDX_PAY_LEN, {16'h0, pay});
      wr(tfg_pkg::IDX_GAP_LEN, {24'h0, gap});
      wr(tfg_pkg::IDX_IRQ_MASK, (p == 3) ? 32'h0 : 32'h80);
      wr(tfg_pkg::IDX_CTRL, 32'(p));
      base = frames;
      wr(tfg_pkg::IDX_GEN_EN, 32'h1);
      // MAC traffic starts once the generator owns the link
      mac_tx_en   <= 1'b1;
      mac_tx_data <= md;
      wait_done();
      `CHK("done", 32'h1, rdat)
      chk_rd("done clear", tfg_pkg::IDX_DONE, 32'h0);
      `CHK("frames", base + 16'd2, frames)
      `CHK("length", pay + 16'd18, flen)
      `CHK("gap", {8'h0, gap}, fgap)
      `CHK("len field", pay, lenf)
      `CHK("payload", exp_pay(3'(p)), pbytes)
      @(negedge pclk);
      `CHK("irq", p != 3, irq)
      chk_rd("status", tfg_pkg::IDX_IRQ_STAT, 32'h80);
      wr(tfg_pkg::IDX_IRQ_STAT, 32'h80);
      @(negedge pclk);
      `CHK("irq clear", 1'b0, irq)
      wr(tfg_pkg::IDX_CTRL, 32'(p) | 32'h8);
      wait_done();
      `CHK("restart", base + 16'd4, frames)
      chk_rd("ctrl", tfg_pkg::IDX_CTRL, 32'(p));
      wr(tfg_pkg::IDX_IRQ_STAT, 32'h80);
      mac_tx_en <= 1'b0;
      wr(tfg_pkg::IDX_GEN_EN, 32'h0);
    end
    wr(tfg_pkg::IDX_GAP_LEN, 32'h28);
    wr(tfg_pkg::IDX_CNT_LOW, 32'h1);
    wr(tfg_pkg::IDX_CONT, 32'h1);
    base = frames;
    wr(tfg_pkg::IDX_GEN_EN, 32'h1);
    for (int n = 0; n < 3000 && frames - base < 16'd3; n++)
      @(posedge pclk);
    `CHK("cont frames", 1'b1, frames - base >= 16'd3)
    chk_rd("cont done", tfg_pkg::IDX_DONE, 32'h0);
    wr(tfg_pkg::IDX_CTRL, 32'h0);
    base = frames;
    repeat (300)
      @(posedge pclk);
    `CHK("stop frames", 1'b1, frames - base <= 16'd1)
    chk_rd("stop done", tfg_pkg::IDX_DONE, 32'h0);
    while (phy_tx_en === 1'b1)
      @(posedge pclk);
    wr(tfg_pkg::IDX_GEN_EN, 32'h0);
    repeat (8)
    begin
      me = 1'($random(seed));
      md = 8'($random(seed)) & 8'h7f;
      @(posedge pclk);
      mac_tx_en   <= me;
      mac_tx_data <= md;
      @(posedge pclk);
      @(negedge pclk);
      `CHK("mac pass", {me, me ? md : 8'h0}, {phy_tx_en, me ? phy_tx_data : 8'h0})
    end
    wrap_up();
  end
endmodule
`default_nettype wire
